// >>> tei_params.svh
`ifndef TEI_PARAMS_SVH
`define TEI_PARAMS_SVH

// Register offsets on the plain software port.
`define TEI_OFF_PIN_EN 5'h00
`define TEI_OFF_EDGE_SEL 5'h04
`define TEI_OFF_PEND 5'h08
`define TEI_OFF_CTRL 5'h0c
`define TEI_OFF_STATUS 5'h10

// Field positions.
`define TEI_CTRL_PORT_EN 0
`define TEI_STAT_PORT_REQ 0
`define TEI_STAT_LOW_POWER 1

// Reset values.
`define TEI_RST_PIN_EN 8'h00
`define TEI_RST_EDGE_SEL 8'h00
`define TEI_RST_PEND 8'h00
`define TEI_RST_PORT_EN 1'b0

// Opcode and address constants.
`define TEI_OPC_TRAP 8'h00
`define TEI_PROG_LAST 15'h0fff
`define TEI_STACK_LIM_SMALL 8'h2f
`define TEI_STACK_LIM_LARGE 8'h6f

// Low bytes of the vector slots, high byte at the even offset.
`define TEI_VEC_TRAP 8'hfe
`define TEI_VEC_PORT 8'he2
`define TEI_VEC_DEFAULT 8'he0

`endif

// >>> tei_pkg.sv
package tei_pkg;

  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] s3;
    logic [7:0] stable;
    logic [7:0] rise;
    logic [7:0] fall;
  } tei_edge_st_t;

  typedef struct packed {
    logic pend;
  } tei_trap_st_t;

  typedef struct packed {
    logic [7:0] pin_en;
    logic [7:0] edge_sel;
    logic [7:0] pend;
    logic port_en;
    logic [7:0] rdata;
    logic [7:0] ir;
    logic [14:0] ret_addr;
    logic trap_req;
    logic irq_req;
    logic [7:0] vec_low;
    logic vec_valid;
    logic wake;
    logic wake_isr;
  } tei_top_st_t;

endpackage

// >>> tei_link_if.sv
`timescale 1ns/1ps
interface tei_link_if;
  logic [7:0] rise;
  logic [7:0] fall;
  logic trap_set;
  logic trap_clr;
  logic trap_pend;

  modport edge_mp (output rise, output fall);
  modport trap_mp (input trap_set, input trap_clr, output trap_pend);
  modport top_mp (input rise, input fall, input trap_pend, output trap_set, output trap_clr);
endinterface

// >>> tei_edge_sync.sv
`timescale 1ns/1ps
module tei_edge_sync
  import tei_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] pin,
  tei_link_if.edge_mp lnk
);

  tei_edge_st_t st;
  tei_edge_st_t next_st;

  // The first stage feeds only the second; a level counts once stages two and three agree.
  always_comb begin
    next_st = st;
    next_st.s1 = pin;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.stable = (~(st.s2 ^ st.s3) & st.s3) | ((st.s2 ^ st.s3) & st.stable);
    next_st.rise = next_st.stable & ~st.stable;
    next_st.fall = ~next_st.stable & st.stable;
  end

  // Registers the whole state; reset loads constants only.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign lnk.rise = st.rise;
  assign lnk.fall = st.fall;

endmodule

// >>> tei_trap_flag.sv
`timescale 1ns/1ps
module tei_trap_flag
  import tei_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  tei_link_if.trap_mp lnk
);

  tei_trap_st_t st;
  tei_trap_st_t next_st;

  // Hidden flag: no address reaches it. A trap in the clearing cycle still sets it.
  always_comb begin
    next_st = st;
    if (lnk.trap_clr) begin
      next_st.pend = 1'b0;
    end
    if (lnk.trap_set) begin
      next_st.pend = 1'b1;
    end
  end

  // Device reset clears the flag.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign lnk.trap_pend = st.pend;

endmodule

// >>> tei_top.sv
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "tei_params.svh"

module tei_top
  import tei_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic [4:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic [7:0] WAKE_PIN,
  input wire logic GLOBAL_IRQ_ENABLE,
  input wire logic IN_SERVICE,
  input wire logic LOW_POWER,
  input wire logic LARGE_RAM,
  input wire logic FETCH_IR,
  input wire logic [14:0] FETCH_ADDR,
  input wire logic [7:0] FETCH_BYTE,
  input wire logic STACK_POP,
  input wire logic [7:0] SP_AFTER_POP,
  input wire logic CLEAR_TRAP_PENDING_INSTR,
  input wire logic VECTOR_SELECT_INSTR,
  output logic [7:0] INSTR_REG,
  output logic [14:0] TRAP_RET_ADDR,
  output logic TRAP_REQ,
  output logic PORT_IRQ_REQ,
  output logic [7:0] VECTOR_LOW,
  output logic VECTOR_VALID,
  output logic WAKE,
  output logic WAKE_TO_ISR
);

  tei_top_st_t st;
  tei_top_st_t next_st;
  tei_link_if lnk ();

  // Address match for the register port, shared by the write and read paths.
  function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
    hit = (a == off);
  endfunction

  // Edge detection on the external pins lives in its own synchroniser.
  tei_edge_sync u_edge (
    .clk(MCLK),
    .rst_b(RST_B),
    .pin(WAKE_PIN),
    .lnk(lnk.edge_mp)
  );

  // The hidden trap flag is kept apart so nothing on the bus can reach it.
  tei_trap_flag u_trap (
    .clk(MCLK),
    .rst_b(RST_B),
    .lnk(lnk.trap_mp)
  );

  logic [7:0] fetched;
  logic ir_trap;
  logic [7:0] stack_limit;
  logic pop_trap;
  logic trap_event;
  logic [7:0] trig;
  logic [7:0] armed;
  logic port_req;
  logic [7:0] pend_clr;

  // Zero bytes appear past the last implemented program address.
  always_comb begin
    if (FETCH_ADDR > `TEI_PROG_LAST) begin
      fetched = 8'h00;
    end else begin
      fetched = FETCH_BYTE;
    end
  end

  // Trap sources: acknowledge opcode reaching the IR, or a stack overpop.
  // Every IR load is checked, whatever brought the fetch about.
  always_comb begin
    ir_trap = FETCH_IR && (fetched == `TEI_OPC_TRAP);
    stack_limit = LARGE_RAM ? `TEI_STACK_LIM_LARGE : `TEI_STACK_LIM_SMALL;
    pop_trap = STACK_POP && (SP_AFTER_POP > stack_limit);
    trap_event = ir_trap || pop_trap;
  end

  // Feed the flag keeper. Clear and set may coincide; the set wins there.
  assign lnk.trap_set = trap_event;
  assign lnk.trap_clr = CLEAR_TRAP_PENDING_INSTR;

  // Per-pin trigger: select bit low picks the rising edge, high picks falling.
  always_comb begin
    trig = (lnk.rise & ~st.edge_sel) | (lnk.fall & st.edge_sel);
    armed = st.pend & st.pin_en;
  end

  // All eight pins merge into one request and one vector.
  always_comb begin
    port_req = GLOBAL_IRQ_ENABLE && st.port_en && (|armed);
  end

  // Pending bits are cleared by writing ones to them.
  always_comb begin
    pend_clr = 8'h00;
    if (WR && hit(ADDR, `TEI_OFF_PEND)) begin
      pend_clr = WDATA;
    end
  end

  // Next state of everything the top keeps.
  always_comb begin
    next_st = st;

    // Configuration writes.
    if (WR && hit(ADDR, `TEI_OFF_PIN_EN)) begin
      next_st.pin_en = WDATA;
    end
    if (WR && hit(ADDR, `TEI_OFF_EDGE_SEL)) begin
      next_st.edge_sel = WDATA;
    end
    if (WR && hit(ADDR, `TEI_OFF_CTRL)) begin
      next_st.port_en = WDATA[`TEI_CTRL_PORT_EN];
    end

    // A trigger landing in the clearing cycle survives the clear.
    next_st.pend = (st.pend & ~pend_clr) | trig;

    // Read data stand only in the cycle after the read strobe.
    // The trap flag is deliberately absent from every readable word.
    next_st.rdata = 8'h00;
    if (RD) begin
      if (hit(ADDR, `TEI_OFF_PIN_EN)) begin
        next_st.rdata = st.pin_en;
      end else if (hit(ADDR, `TEI_OFF_EDGE_SEL)) begin
        next_st.rdata = st.edge_sel;
      end else if (hit(ADDR, `TEI_OFF_PEND)) begin
        next_st.rdata = st.pend;
      end else if (hit(ADDR, `TEI_OFF_CTRL)) begin
        next_st.rdata = {7'h00, st.port_en};
      end else if (hit(ADDR, `TEI_OFF_STATUS)) begin
        next_st.rdata = {6'h00, LOW_POWER, port_req};
      end else begin
        next_st.rdata = 8'h00;
      end
    end

    // Instruction register and the return address of a trap.
    // The address kept is that of the trapping byte, so a plain return would repeat it.
    if (FETCH_IR) begin
      next_st.ir = fetched;
    end
    if (ir_trap) begin
      next_st.ret_addr = FETCH_ADDR;
    end

    // The trap request goes out at once, even inside a maskable routine,
    // and never touches the global enable.
    next_st.trap_req = trap_event;

    // Maskable port request: held off by a pending trap or a routine in progress.
    next_st.irq_req = port_req && !lnk.trap_pend && !trap_event && !IN_SERVICE;

    // Vector selection: trap first, then the port, else the default slot.
    next_st.vec_valid = VECTOR_SELECT_INSTR;
    if (VECTOR_SELECT_INSTR) begin
      if (lnk.trap_pend || trap_event) begin
        next_st.vec_low = `TEI_VEC_TRAP;
      end else if (port_req) begin
        next_st.vec_low = `TEI_VEC_PORT;
      end else begin
        next_st.vec_low = `TEI_VEC_DEFAULT;
      end
    end

    // Wake from a low-power mode on any enabled trigger.
    // With the port interrupt or the global enable off the core resumes after the halting instruction;
    // with both on the core runs the port routine first.
    next_st.wake = LOW_POWER && (|(trig & st.pin_en));
    next_st.wake_isr = 1'b0;
    if (LOW_POWER && (|(trig & st.pin_en))) begin
      next_st.wake_isr = GLOBAL_IRQ_ENABLE && st.port_en;
    end
  end

  // State register; reset values are constants only.
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      st.pin_en <= `TEI_RST_PIN_EN;
      st.edge_sel <= `TEI_RST_EDGE_SEL;
      st.pend <= `TEI_RST_PEND;
      st.port_en <= `TEI_RST_PORT_EN;
      st.rdata <= 8'h00;
      st.ir <= 8'h00;
      st.ret_addr <= 15'h0000;
      st.trap_req <= 1'b0;
      st.irq_req <= 1'b0;
      st.vec_low <= `TEI_VEC_DEFAULT;
      st.vec_valid <= 1'b0;
      st.wake <= 1'b0;
      st.wake_isr <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // Every output is a register bit of the state.
  assign RDATA = st.rdata;
  assign INSTR_REG = st.ir;
  assign TRAP_RET_ADDR = st.ret_addr;
  assign TRAP_REQ = st.trap_req;
  assign PORT_IRQ_REQ = st.irq_req;
  assign VECTOR_LOW = st.vec_low;
  assign VECTOR_VALID = st.vec_valid;
  assign WAKE = st.wake;
  assign WAKE_TO_ISR = st.wake_isr;

endmodule

// >>> tei_chk_sva.sv
`timescale 1ns/1ps
module tei_chk (
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic GLOBAL_IRQ_ENABLE,
  input wire logic LOW_POWER,
  input wire logic LARGE_RAM,
  input wire logic FETCH_IR,
  input wire logic [14:0] FETCH_ADDR,
  input wire logic [7:0] FETCH_BYTE,
  input wire logic STACK_POP,
  input wire logic [7:0] SP_AFTER_POP,
  input wire logic VECTOR_SELECT_INSTR,
  input wire logic [7:0] INSTR_REG,
  input wire logic [14:0] TRAP_RET_ADDR,
  input wire logic TRAP_REQ,
  input wire logic PORT_IRQ_REQ,
  input wire logic [7:0] VECTOR_LOW,
  input wire logic VECTOR_VALID,
  input wire logic WAKE,
  input wire logic WAKE_TO_ISR
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_B);
  // Unimplemented program space reads as zero, so such fetches trap as well.
  wire ir_trap = FETCH_IR && (FETCH_BYTE == 8'h00 || FETCH_ADDR > 15'h0fff);
  wire pop_trap = STACK_POP && SP_AFTER_POP > (LARGE_RAM ? 8'h6f : 8'h2f);
  sequence s_ir_trap;
    ir_trap ##1 TRAP_REQ;
  endsequence
  AST_IR_TRAP: assert property (ir_trap |=> TRAP_REQ && INSTR_REG == 8'h00)
    else $error("fetch trap missing");
  AST_RET_ADDR: assert property (s_ir_trap |-> TRAP_RET_ADDR == $past(FETCH_ADDR))
    else $error("return address wrong");
  AST_POP_TRAP: assert property (pop_trap |=> TRAP_REQ)
    else $error("overpop trap missing");
  AST_TRAP_BLOCK: assert property (TRAP_REQ |-> !PORT_IRQ_REQ [*2])
    else $error("port request during trap");
  AST_VEC_TRAP: assert property (VECTOR_SELECT_INSTR && TRAP_REQ |=> VECTOR_VALID && VECTOR_LOW == 8'hfe)
    else $error("trap vector wrong");
  AST_GIE_GATE: assert property (!GLOBAL_IRQ_ENABLE [*2] |-> !PORT_IRQ_REQ)
    else $error("port request without global enable");
  AST_WAKE: assert property (WAKE |-> $past(LOW_POWER))
    else $error("wake outside low power");
  AST_WAKE_ISR: assert property (WAKE_TO_ISR |-> WAKE && $past(GLOBAL_IRQ_ENABLE))
    else $error("wake routing wrong");
endmodule
bind tei_top tei_chk u_chk (.*);

// >>> tei_pin_model.sv
`timescale 1ns/1ps
// Board-side pin source; in slow mode it only moves on every other clock.
module tei_pin_model (
  input wire logic clk,
  input wire logic slow,
  input wire logic [7:0] target,
  output logic [7:0] pins
);
  logic tick = 1'b0;
  initial pins = 8'h00;
  // Pins move just after the edge, as a real source on this clock would.
  always @(posedge clk) begin
    tick <= ~tick;
    if (!slow || tick) pins <= target;
  end
endmodule

// >>> trap_and_edge_interrupt_logic_tb_top.sv
`timescale 1ns/1ps
module trap_and_edge_interrupt_logic_tb_top;
  logic MCLK = 1'b0, RST_B = 1'b0, WR = 1'b0, RD = 1'b0, GLOBAL_IRQ_ENABLE = 1'b0, IN_SERVICE = 1'b0;
  logic LOW_POWER = 1'b0, LARGE_RAM = 1'b0, FETCH_IR = 1'b0, STACK_POP = 1'b0, slow = 1'b0;
  logic CLEAR_TRAP_PENDING_INSTR = 1'b0, VECTOR_SELECT_INSTR = 1'b0;
  logic [4:0] ADDR = '0;
  logic [7:0] WDATA = '0, FETCH_BYTE = '0, SP_AFTER_POP = '0, tgt = '0;
  logic [7:0] WAKE_PIN, RDATA, INSTR_REG, VECTOR_LOW, d;
  logic [14:0] FETCH_ADDR = '0, TRAP_RET_ADDR;
  logic TRAP_REQ, PORT_IRQ_REQ, VECTOR_VALID, WAKE, WAKE_TO_ISR;
  int n_mismatch = 0, checks_done = 0, pend_m = 0, cur = 0, esel = 0;
  tei_top DUT (.*);
  tei_pin_model u_pins (.clk(MCLK), .slow(slow), .target(tgt), .pins(WAKE_PIN));
  initial forever #50 MCLK = ~MCLK;
  task chk(input logic [14:0] got, input logic [14:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task wr_reg(input logic [4:0] a, input logic [7:0] v);
    @(posedge MCLK);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    @(posedge MCLK);
    WR <= 1'b0;
  endtask
  task rd_reg(input logic [4:0] a);
    @(posedge MCLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge MCLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask
  // One-cycle fetch strobe; the trap answer is looked at just after the edge that takes it.
  task fetch(input logic [14:0] a, input logic [7:0] b);
    int t;
    t = b == 8'h00 || a > 15'h0fff;
    @(posedge MCLK);
    FETCH_IR <= 1'b1;
    FETCH_ADDR <= a;
    FETCH_BYTE <= b;
    @(posedge MCLK);
    FETCH_IR <= 1'b0;
    #1 chk(TRAP_REQ, t);
    chk(INSTR_REG, t ? 0 : b);
    if (t) chk(TRAP_RET_ADDR, a);
  endtask
  task vsel(input logic [7:0] v);
    @(posedge MCLK);
    VECTOR_SELECT_INSTR <= 1'b1;
    @(posedge MCLK);
    VECTOR_SELECT_INSTR <= 1'b0;
    #1 chk(VECTOR_VALID, 1);
    chk(VECTOR_LOW, v);
  endtask
  task clear_trap;
    @(posedge MCLK);
    CLEAR_TRAP_PENDING_INSTR <= 1'b1;
    @(posedge MCLK);
    CLEAR_TRAP_PENDING_INSTR <= 1'b0;
  endtask
  // Reference model of the pending latches: every selected edge sets its bit.
  task move(input int n);
    pend_m |= ((~cur & n & ~esel) | (cur & ~n & esel)) & 'hff;
    cur = n;
    tgt <= n[7:0];
  endtask
  task settle(input logic x);
    repeat (3) @(posedge MCLK);
    #1 chk(PORT_IRQ_REQ, x);
  endtask
  // The partner may be slow, so the wake pulse is searched for under a bound.
  task wait_wake(input logic x);
    repeat (20) begin
      @(posedge MCLK);
      #1 if (WAKE === 1'b1) break;
    end
    chk(WAKE, 1);
    chk(WAKE_TO_ISR, x);
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #1ms;
    n_mismatch++;
    summarize;
  end
  initial begin
    int p;
    void'($urandom(43596));
    repeat (10) @(posedge MCLK);
    RST_B <= 1'b1;
    fetch(15'h0123, 8'h00);
    // While the trap flag is set, no address may reveal it.
    for (int a = 0; a < 32; a++) begin
      rd_reg(a[4:0]);
      chk(d, 0);
    end
    vsel(8'hfe);
    clear_trap;
    vsel(8'he0);
    IN_SERVICE <= 1'b1;
    for (int i = 0; i < 6; i++) fetch(15'($urandom), i[0] ? 8'h00 : 8'($urandom_range(255, 1)));
    fetch(15'h1000, 8'h5a);
    IN_SERVICE <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      @(posedge MCLK);
      STACK_POP <= 1'b1;
      LARGE_RAM <= i > 1;
      SP_AFTER_POP <= (i > 1 ? 8'h6f : 8'h2f) + 8'(i % 2);
      @(posedge MCLK);
      STACK_POP <= 1'b0;
      #1 chk(TRAP_REQ, i % 2);
    end
    clear_trap;
    esel = $urandom_range(255, 0);
    wr_reg(5'h00, 8'hff);
    wr_reg(5'h04, esel[7:0]);
    wr_reg(5'h0c, 8'h01);
    GLOBAL_IRQ_ENABLE <= 1'b1;
    p = $urandom_range(255, 1);
    for (int i = 0; i < 2; i++) begin
      move(i ? 0 : p);
      slow <= i[0];
      repeat (10) @(posedge MCLK);
      rd_reg(5'h08);
      chk(d, pend_m);
    end
    chk(PORT_IRQ_REQ, 1);
    vsel(8'he2);
    IN_SERVICE <= 1'b1;
    settle(0);
    IN_SERVICE <= 1'b0;
    GLOBAL_IRQ_ENABLE <= 1'b0;
    settle(0);
    GLOBAL_IRQ_ENABLE <= 1'b1;
    wr_reg(5'h0c, 8'h00);
    settle(0);
    wr_reg(5'h0c, 8'h01);
    fetch(15'h0200, 8'h00);
    chk(PORT_IRQ_REQ, 0);
    vsel(8'hfe);
    clear_trap;
    settle(1);
    wr_reg(5'h08, 8'hff);
    pend_m = 0;
    rd_reg(5'h08);
    chk(d, pend_m);
    wr_reg(5'h00, 8'h00);
    wr_reg(5'h04, 8'h00);
    esel = 0;
    move(cur ^ 1);
    repeat (10) @(posedge MCLK);
    rd_reg(5'h08);
    chk(d, pend_m);
    settle(0);
    wr_reg(5'h00, 8'h01);
    LOW_POWER <= 1'b1;
    esel = cur[0] ? 1 : 0;
    wr_reg(5'h04, esel[7:0]);
    move(cur ^ 1);
    wait_wake(1);
    GLOBAL_IRQ_ENABLE <= 1'b0;
    esel = cur[0] ? 1 : 0;
    wr_reg(5'h04, esel[7:0]);
    move(cur ^ 1);
    wait_wake(0);
    summarize;
  end
endmodule
